// ===== hw/srb_defines.vh
// Purpose: constants of the segmented sweep ring buffer with trigger
// Assumes: included by bare name from the design file
// Notes:   definitions only; widths fixed
`ifndef SRB_DEFINES_VH
`define SRB_DEFINES_VH
// storage geometry
`define SRB_AW          10
`define SRB_DEPTH       1024
`define SRB_DW          16
`define SRB_LENW        11
`define SRB_SEGW        4
`define SRB_CNTW        16
`define SRB_NCH         8
`define SRB_PRODW       15
// register byte offsets (low address byte)
`define SRB_OFFW        8
`define SRB_OFF_CFG     8'h00
`define SRB_OFF_CMD     8'h04
`define SRB_OFF_SEGLEN  8'h08
`define SRB_OFF_SEGCNT  8'h0c
`define SRB_OFF_DELAY   8'h10
`define SRB_OFF_DIV     8'h14
`define SRB_OFF_STATUS  8'h18
`define SRB_OFF_TRIGADR 8'h1c
`define SRB_OFF_RDADR   8'h20
`define SRB_OFF_RDDATA  8'h24
// storage modes
`define SRB_MODE_SWEEP  2'h0
`define SRB_MODE_STD    2'h1
`define SRB_MODE_CIRC   2'h2
`define SRB_MODE_SOT    2'h3
// field positions
`define SRB_CFG_EXT     2
`define SRB_CFG_BIN     3
`define SRB_CMD_RUN     0
`define SRB_CMD_STOP    1
`define SRB_CMD_PAUSE   2
`define SRB_CMD_TRIG    3
`define SRB_ST_DONE     0
// reset values
`define SRB_CFG_RST     4'h0
`define SRB_SEGLEN_RST  11'h400
`define SRB_SEGCNT_RST  4'h1
`define SRB_DELAY_RST   16'h0000
`define SRB_DIV_RST     16'h0001
// time base
`define SRB_HCLK_HZ     64'd100000000
`define SRB_MAIN_DEC_HZ 64'd1000000
`define SRB_MAIN_BIN_HZ 64'd1024000
`define SRB_ACC_SHIFT   32
`define SRB_ACCW        32
`endif

// ===== hw/srb_sweep_ring_buffer.v
// Purpose: segmented sweep ring buffer with trigger delay and continuous
//          streaming modes, registers over AHB-Lite
// Assumes: sample valid, channel triggers and external clock are synchronous
//          to hclk; host stream path always accepts
// Notes:   reads have one wait state, writes none; response always OKAY
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "srb_defines.vh"
module srb_sweep_ring_buffer (
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     hsel,
  input  wire [31:0]              haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [31:0]              hwdata,
  input  wire                     hready,
  output wire                     hreadyout,
  output wire                     hresp,
  output reg  [31:0]              hrdata,
  output reg                      adc_start,
  input  wire                     adc_valid,
  input  wire [`SRB_DW-1:0]       adc_data,
  input  wire                     ext_clk,
  input  wire [`SRB_NCH-1:0]      chan_trig,
  output reg                      strm_valid,
  output reg  [`SRB_DW-1:0]       strm_data,
  output reg  [`SRB_CNTW-1:0]     strm_addr,
  output reg                      xfer_valid,
  output reg  [`SRB_DW-1:0]       xfer_data,
  output reg                      xfer_last,
  input  wire                     xfer_ready,
  output reg                      mf_clk_binary
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_POST = 2'h2;
  localparam [1:0] S_XFER = 2'h3;
  localparam [63:0] INC_DEC = ((`SRB_MAIN_DEC_HZ << `SRB_ACC_SHIFT) + (`SRB_HCLK_HZ >> 1))
                              / `SRB_HCLK_HZ;
  localparam [63:0] INC_BIN = ((`SRB_MAIN_BIN_HZ << `SRB_ACC_SHIFT) + (`SRB_HCLK_HZ >> 1))
                              / `SRB_HCLK_HZ;

  // next ring offset, used by the writer and by the transfer reader
  function [`SRB_LENW-1:0] ring_inc;
    input [`SRB_LENW-1:0] off;
    input [`SRB_LENW-1:0] len;
    begin
      if (off + 11'h001 >= len) begin
        ring_inc = 11'h000;
      end else begin
        ring_inc = off + 11'h001;
      end
    end
  endfunction

  reg [`SRB_DW-1:0]   mem [0:`SRB_DEPTH-1];
  reg [3:0]           cfg_reg;
  reg [`SRB_LENW-1:0] seglen_reg;
  reg [`SRB_SEGW-1:0] segcnt_reg;
  reg [`SRB_CNTW-1:0] delay_reg;
  reg [`SRB_CNTW-1:0] div_reg;
  reg [`SRB_AW-1:0]   rdadr_reg;
  reg [`SRB_AW-1:0]   trigadr_reg;
  reg                 done_reg;
  reg [1:0]           state_reg;
  reg                 paused_reg;
  reg                 session_reg;
  reg [`SRB_LENW-1:0] off_reg;
  reg                 wrapped_reg;
  reg [`SRB_SEGW-1:0] seg_reg;
  reg [`SRB_CNTW-1:0] post_reg;
  reg [`SRB_CNTW-1:0] cnt_reg;
  reg [`SRB_LENW-1:0] rd_reg;
  reg [`SRB_LENW-1:0] left_reg;
  reg [`SRB_ACCW-1:0] acc_reg;
  reg [`SRB_CNTW-1:0] divcnt_reg;
  reg                 ext_prev_reg;
  reg                 wr_pend_reg;
  reg                 rd_pend_reg;
  reg [`SRB_OFFW-1:0] ph_addr_reg;

  // bus decode; writes act in the data phase on the captured address
  wire                 bus_go   = hsel & hready & htrans[1];
  wire                 wr_go    = wr_pend_reg;
  wire [`SRB_OFFW-1:0] wr_off   = ph_addr_reg;
  wire                 cmd_wr   = wr_go & (wr_off == `SRB_OFF_CMD);
  wire                 cmd_run  = cmd_wr & hwdata[`SRB_CMD_RUN];
  wire                 cmd_stop = cmd_wr & hwdata[`SRB_CMD_STOP];
  wire                 cmd_pause = cmd_wr & hwdata[`SRB_CMD_PAUSE];
  wire                 man_trig = cmd_wr & hwdata[`SRB_CMD_TRIG];
  wire [1:0]           mode     = cfg_reg[1:0];
  wire                 ring_mem = (mode == `SRB_MODE_SWEEP);

  // one wait state on reads so a preceding write has settled
  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'b0;

  // any channel trigger, or the manual one, triggers the recorder
  wire trig = (|chan_trig) | man_trig;

  // effective segment geometry; zero length is taken as one
  wire [`SRB_LENW-1:0]  seglen = (seglen_reg == 11'h000) ? 11'h001 : seglen_reg;
  wire [`SRB_PRODW-1:0] prod   = seg_reg * seglen;
  wire [`SRB_AW-1:0]    base   = prod[`SRB_AW-1:0];
  wire [`SRB_LENW-1:0]  wsum   = {1'b0, base} + off_reg;
  wire [`SRB_AW-1:0]    wr_adr = wsum[`SRB_AW-1:0];
  wire [`SRB_LENW-1:0]  rsum   = {1'b0, base} + rd_reg;
  wire [`SRB_AW-1:0]    rd_adr = rsum[`SRB_AW-1:0];

  // time base: phase accumulator gives the main oscillator tick
  wire [`SRB_ACCW-1:0] inc = cfg_reg[`SRB_CFG_BIN] ? INC_BIN[`SRB_ACCW-1:0]
                                                   : INC_DEC[`SRB_ACCW-1:0];
  wire [`SRB_ACCW:0]   acc_sum   = {1'b0, acc_reg} + {1'b0, inc};
  wire                 main_tick = acc_sum[`SRB_ACCW];
  wire [`SRB_CNTW-1:0] div_eff   = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
  wire                 int_tick  = main_tick & (divcnt_reg + 16'h0001 >= div_eff);
  wire                 ext_tick  = ext_clk & ~ext_prev_reg;
  wire                 smp_tick  = cfg_reg[`SRB_CFG_EXT] ? ext_tick : int_tick;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg      <= 32'h00000000;
      divcnt_reg   <= 16'h0000;
      ext_prev_reg <= 1'b0;
      adc_start    <= 1'b0;
      mf_clk_binary <= 1'b0;
    end else begin
      acc_reg      <= acc_sum[`SRB_ACCW-1:0];
      ext_prev_reg <= ext_clk;
      if (main_tick) begin
        divcnt_reg <= int_tick ? 16'h0000 : divcnt_reg + 16'h0001;
      end
      // converter runs always, even in pause, for monitoring
      adc_start     <= smp_tick;
      mf_clk_binary <= cfg_reg[`SRB_CFG_BIN];
    end
  end

  // a sample is stored only while recording and not held
  wire storing = (state_reg == S_RUN || state_reg == S_POST) & ~paused_reg;
  wire store   = storing & adc_valid;
  // end events: sweep and stop-on-trigger end on trigger, circular on stop
  wire use_trig = (mode == `SRB_MODE_SWEEP) | (mode == `SRB_MODE_SOT);
  wire end_evt  = (state_reg == S_RUN) &
                  ((use_trig & trig) | ((mode == `SRB_MODE_CIRC) & cmd_stop));
  wire post_hit = (state_reg == S_POST) & store & (post_reg == 16'h0001);
  wire halt     = (end_evt & (delay_reg == 16'h0000)) | post_hit;
  wire abort    = cmd_stop & (state_reg == S_RUN || state_reg == S_POST) & ~end_evt;
  wire xfer_adv = ~xfer_valid | xfer_ready;

  // sample memory write port
  always @(posedge hclk) begin
    if (store & ring_mem) begin
      mem[wr_adr] <= adc_data;
    end
  end

  // recording state machine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg   <= S_IDLE;
      paused_reg  <= 1'b0;
      session_reg <= 1'b0;
      off_reg     <= 11'h000;
      wrapped_reg <= 1'b0;
      seg_reg     <= 4'h0;
      post_reg    <= 16'h0000;
      cnt_reg     <= 16'h0000;
      rd_reg      <= 11'h000;
      left_reg    <= 11'h000;
      trigadr_reg <= 10'h000;
      strm_valid  <= 1'b0;
      strm_data   <= 16'h0000;
      strm_addr   <= 16'h0000;
      xfer_valid  <= 1'b0;
      xfer_data   <= 16'h0000;
      xfer_last   <= 1'b0;
    end else begin
      strm_valid <= 1'b0;
      if (cmd_pause) begin
        paused_reg <= 1'b1;
      end else if (cmd_run | cmd_stop) begin
        paused_reg <= 1'b0;
      end
      if (cmd_stop) begin
        session_reg <= 1'b0;
      end
      // ring pointer on each stored sample, stream output too outside sweep mode
      if (store) begin
        off_reg <= ring_inc(off_reg, seglen);
        if (off_reg + 11'h001 >= seglen) begin
          wrapped_reg <= 1'b1;
        end
        cnt_reg <= cnt_reg + 16'h0001;
        if (!ring_mem) begin
          strm_valid <= 1'b1;
          strm_data  <= adc_data;
          // standard mode has no length limit, so address is free-running
          strm_addr  <= (mode == `SRB_MODE_STD) ? cnt_reg : {5'h00, off_reg};
        end
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_run) begin
            state_reg   <= S_RUN;
            session_reg <= 1'b1;
            off_reg     <= 11'h000;
            wrapped_reg <= 1'b0;
            seg_reg     <= 4'h0;
            cnt_reg     <= 16'h0000;
          end
        end
        S_RUN: begin
          if (end_evt) begin
            trigadr_reg <= wr_adr;
            post_reg    <= delay_reg;
          end
          if (abort) begin
            state_reg <= S_IDLE;
          end else if (halt) begin
            state_reg <= ring_mem ? S_XFER : S_IDLE;
          end else if (end_evt) begin
            state_reg <= S_POST;
          end
        end
        S_POST: begin
          // one count per stored sample; delay beyond segment keeps wrapping
          if (store) begin
            post_reg <= post_reg - 16'h0001;
          end
          if (abort) begin
            state_reg <= S_IDLE;
          end else if (post_hit) begin
            state_reg <= ring_mem ? S_XFER : S_IDLE;
          end
        end
        default: begin
          // stream segment out oldest first, then rearm next segment
          if (xfer_adv) begin
            if (left_reg != 11'h000) begin
              xfer_valid <= 1'b1;
              xfer_data  <= mem[rd_adr];
              xfer_last  <= (left_reg == 11'h001);
              rd_reg     <= ring_inc(rd_reg, seglen);
              left_reg   <= left_reg - 11'h001;
            end else begin
              xfer_valid  <= 1'b0;
              xfer_last   <= 1'b0;
              off_reg     <= 11'h000;
              wrapped_reg <= 1'b0;
              seg_reg     <= (seg_reg + 4'h1 >= segcnt_reg) ? 4'h0 : seg_reg + 4'h1;
              state_reg   <= (session_reg & ~cmd_stop) ? S_RUN : S_IDLE;
            end
          end
        end
      endcase
      // transfer start point set as the sweep halts
      if (halt | post_hit) begin
        rd_reg   <= wrapped_reg ? off_reg : 11'h000;
        left_reg <= wrapped_reg ? seglen : off_reg;
        if (store & ~wrapped_reg) begin
          left_reg <= (off_reg + 11'h001 >= seglen) ? seglen : off_reg + 11'h001;
        end
        if (store & wrapped_reg) begin
          rd_reg <= ring_inc(off_reg, seglen);
        end
      end
    end
  end

  // bus address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_go & hwrite;
      rd_pend_reg <= bus_go & ~hwrite;
      if (bus_go) begin
        ph_addr_reg <= haddr[`SRB_OFFW-1:0];
      end
    end
  end

  // register writes; done flag set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg    <= `SRB_CFG_RST;
      seglen_reg <= `SRB_SEGLEN_RST;
      segcnt_reg <= `SRB_SEGCNT_RST;
      delay_reg  <= `SRB_DELAY_RST;
      div_reg    <= `SRB_DIV_RST;
      rdadr_reg  <= 10'h000;
      done_reg   <= 1'b0;
    end else begin
      if (wr_go) begin
        if (wr_off == `SRB_OFF_CFG) begin
          cfg_reg <= hwdata[3:0];
        end else if (wr_off == `SRB_OFF_SEGLEN) begin
          seglen_reg <= hwdata[`SRB_LENW-1:0];
        end else if (wr_off == `SRB_OFF_SEGCNT) begin
          segcnt_reg <= hwdata[`SRB_SEGW-1:0];
        end else if (wr_off == `SRB_OFF_DELAY) begin
          delay_reg <= hwdata[`SRB_CNTW-1:0];
        end else if (wr_off == `SRB_OFF_DIV) begin
          div_reg <= hwdata[`SRB_CNTW-1:0];
        end else if (wr_off == `SRB_OFF_RDADR) begin
          rdadr_reg <= hwdata[`SRB_AW-1:0];
        end
      end
      if (halt) begin
        done_reg <= 1'b1;
      end else if (wr_go & (wr_off == `SRB_OFF_STATUS) & hwdata[`SRB_ST_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // read data, built during the wait state
  wire rd_open = (state_reg == S_IDLE) | (state_reg == S_XFER);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_reg) begin
      if (ph_addr_reg == `SRB_OFF_CFG) begin
        hrdata <= {28'h0000000, cfg_reg};
      end else if (ph_addr_reg == `SRB_OFF_SEGLEN) begin
        hrdata <= {21'h000000, seglen_reg};
      end else if (ph_addr_reg == `SRB_OFF_SEGCNT) begin
        hrdata <= {28'h0000000, segcnt_reg};
      end else if (ph_addr_reg == `SRB_OFF_DELAY) begin
        hrdata <= {16'h0000, delay_reg};
      end else if (ph_addr_reg == `SRB_OFF_DIV) begin
        hrdata <= {16'h0000, div_reg};
      end else if (ph_addr_reg == `SRB_OFF_STATUS) begin
        hrdata <= {21'h000000, state_reg, wrapped_reg, seg_reg, paused_reg,
                   session_reg, (state_reg == S_XFER), done_reg};
      end else if (ph_addr_reg == `SRB_OFF_TRIGADR) begin
        hrdata <= {22'h000000, trigadr_reg};
      end else if (ph_addr_reg == `SRB_OFF_RDADR) begin
        hrdata <= {22'h000000, rdadr_reg};
      end else if (ph_addr_reg == `SRB_OFF_RDDATA) begin
        // memory visible only once storage has stopped
        hrdata <= rd_open ? {16'h0000, mem[rdadr_reg]} : 32'h00000000;
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end
endmodule

// ===== tb/srb_adc_model.sv
// Purpose: converter model answering each convert strobe
// Assumes: strobe is a one-cycle pulse
// Notes:   slow adds three cycles of conversion latency
`timescale 1ns/10ps
module srb_adc_model (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        adc_start,
  input  wire        slow,
  output reg         adc_valid,
  output reg  [15:0] adc_data
);
  reg [2:0]  wait_cnt;
  reg [15:0] conv;
  // one sample per strobe; idle data toggles so no stale value shows
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_valid <= 1'b0;
      adc_data  <= 16'h0000;
      wait_cnt  <= 3'h0;
      conv      <= 16'h0a5c;
    end else begin
      adc_valid <= wait_cnt == 3'h1;
      adc_data  <= wait_cnt == 3'h1 ? conv : ~adc_data;
      if (wait_cnt == 3'h1)
        conv <= conv + 16'h1357;
      if (adc_start)
        wait_cnt <= slow ? 3'h4 : 3'h1;
      else if (wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule

// ===== tb/srb_sweep_ring_buffer_chk.sv
// Purpose: port checks for the sweep ring buffer
// Assumes: one clock, async active-low reset
// Notes:   cfg is mirrored from bus writes to qualify the tick checks
`timescale 1ns/10ps
`include "srb_defines.vh"
module srb_sweep_ring_buffer_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        adc_start,
  input wire        adc_valid,
  input wire [15:0] adc_data,
  input wire        ext_clk,
  input wire        strm_valid,
  input wire [15:0] strm_data,
  input wire        xfer_valid,
  input wire [15:0] xfer_data,
  input wire        xfer_last,
  input wire        xfer_ready,
  input wire        mf_clk_binary
);
  reg       cfg_wr;
  reg [3:0] cfg_q;
  reg [7:0] gap;
  reg       gap_ok;
  // mirror lands on the same edge as the design register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_wr <= 1'b0;
      cfg_q  <= 4'h0;
    end else if (hready) begin
      cfg_wr <= hsel && htrans[1] && hwrite && haddr[7:0] == `SRB_OFF_CFG;
      if (cfg_wr)
        cfg_q <= hwdata[3:0];
    end
  end
  // cycles since last tick; a cfg write voids the measurement
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap    <= 8'h00;
      gap_ok <= 1'b0;
    end else if (cfg_wr || adc_start) begin
      gap    <= 8'h00;
      gap_ok <= !cfg_wr;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  tick_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("convert strobe wider than one cycle");
  tick_gap_a: assert property (adc_start && gap_ok && !cfg_q[2] |-> gap >= 8'h5f)
    else $error("internal ticks too close");
  ext_tick_a: assert property (cfg_q[2] && $rose(ext_clk) |-> ##[1:3] adc_start)
    else $error("external edge gave no tick");
  bin_bcast_a: assert property (mf_clk_binary == $past(cfg_q[3]))
    else $error("clock base broadcast wrong");
  strm_copy_a: assert property (
    strm_valid |-> $past(adc_valid) && strm_data == $past(adc_data))
    else $error("stream word not the stored sample");
  xfer_hold_a: assert property (xfer_valid && !xfer_ready |=>
    xfer_valid && $stable(xfer_data) && $stable(xfer_last))
    else $error("transfer word changed while stalled");
  last_end_a: assert property (xfer_valid && xfer_ready && xfer_last |=> !xfer_valid)
    else $error("transfer ran past last word");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cover property (xfer_valid && xfer_ready && xfer_last);
  cover property (strm_valid);
  cover property (cfg_q[3] && adc_start);
endmodule
bind srb_sweep_ring_buffer srb_sweep_ring_buffer_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .adc_start, .adc_valid, .adc_data, .ext_clk,
  .strm_valid, .strm_data, .xfer_valid, .xfer_data, .xfer_last, .xfer_ready, .mf_clk_binary);

// ===== tb/srb_sweep_ring_buffer_tb.sv
// Purpose: self-checking bench for the sweep ring buffer
// Assumes: capture tests use the external time base for speed
// Notes:   expected sweep words come from the samples the converter made
`timescale 1ns/10ps
`include "srb_defines.vh"
module srb_sweep_ring_buffer_tb;
  localparam int SL = 8;  // short segment so wraps come fast
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_clk = 1'b0;
  logic xfer_ready = 1'b0, slow = 1'b0;
  logic hready, hreadyout, hresp, adc_start, adc_valid, strm_valid, xfer_valid, xfer_last;
  logic mf_clk_binary;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  chan_trig = 8'h00;
  logic [15:0] adc_data, strm_data, strm_addr, xfer_data, sa;
  logic [15:0] q[$], xq[$];
  int          errors = 0, cmp_count = 0, scnt = 0, s0 = 0, xn = 0;
  int          dl[5] = '{0, 3, SL - 1, SL, SL + 3};
  logic [7:0]  roff[7] = '{`SRB_OFF_CFG, `SRB_OFF_SEGLEN, `SRB_OFF_SEGCNT, `SRB_OFF_DELAY,
                           `SRB_OFF_DIV, `SRB_OFF_CMD, 8'h30};
  logic [31:0] rval[7] = '{32'h0, 32'h400, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0};

  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  srb_sweep_ring_buffer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .adc_start, .adc_valid, .adc_data, .ext_clk,
    .chan_trig, .strm_valid, .strm_data, .strm_addr, .xfer_valid, .xfer_data, .xfer_last,
    .xfer_ready, .mf_clk_binary);
  srb_adc_model u_adc (.hclk, .hresetn, .adc_start, .slow, .adc_valid, .adc_data);

  // record samples, stream pulses and transferred words; far side stalls a third
  always @(posedge hclk) begin
    if (adc_valid)
      q.push_back(adc_data);
    // counters only grow here, so the bench reads them without a second driver
    if (strm_valid) begin
      scnt++;
      sa <= strm_addr;
    end
    if (xfer_valid && xfer_ready)
      xq.push_back(xfer_data);
    if (xfer_valid && xfer_ready && xfer_last)
      xn++;
    xfer_ready <= ($urandom % 3) != 0;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      wrap_up;
    end
  endtask
  // one single word transfer; read data lands in r
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    r = hrdata;
  endtask
  task ticks(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask
  task trig;
    chan_trig <= 8'h01 << ($urandom % 8);
    @(posedge hclk);
    chan_trig <= 8'h00;
    @(posedge hclk);
  endtask
  // sweep with delay d after k stored samples; last SL stored words come back, or all k + d if fewer
  task sweep(input int d, input int k);
    int s;
    int t;
    int x0;
    q.delete();
    xq.delete();
    x0 = xn;
    slow <= $urandom % 2;
    bus(1, `SRB_OFF_DELAY, d);
    bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_RUN);
    ticks(k);
    trig;
    ticks(d + 2);
    for (int w = 0; w < 600 && xn == x0; w++)
      @(posedge hclk);
    if (xn == x0) begin
      errors++;
      wrap_up;
    end
    s = k + d;
    t = s > SL ? s - SL : 0;
    check(xq.size(), s - t);
    foreach (xq[i])
      check(xq[i], q[t + i]);
    bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_STOP);
    bus(0, `SRB_OFF_TRIGADR, 0);
    check(r, k % SL);
    bus(0, `SRB_OFF_STATUS, 0);
    check(r[0], 1'b1);
    bus(1, `SRB_OFF_STATUS, 32'h1);
    bus(0, `SRB_OFF_STATUS, 0);
    check(r[0], 1'b0);
    bus(1, `SRB_OFF_RDADR, (s - 1) % SL);
    bus(0, `SRB_OFF_RDDATA, 0);
    check(r, q[s - 1]);
  endtask
  // ten tick intervals of the internal time base, in hclk cycles
  task meas(input logic [3:0] cfg, input int div, input int lo, input int hi);
    int n;
    int c;
    n = 0;
    c = 0;
    bus(1, `SRB_OFF_CFG, cfg);
    bus(1, `SRB_OFF_DIV, div);
    for (int w = 0; w < 6000 && n < 12; w++) begin
      @(posedge hclk);
      if (n > 1)
        c++;
      if (adc_start === 1'b1)
        n++;
    end
    if (n < 12) begin
      errors++;
      wrap_up;
    end
    check(c >= lo && c <= hi, 1'b1);
    check(mf_clk_binary, cfg[3]);
  endtask

  initial begin
    void'($urandom(32'h46ff9919));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus(0, roff[i], 0);
      check(r, rval[i]);
      check(hresp, 1'b0);
    end
    bus(1, `SRB_OFF_SEGLEN, SL);
    bus(1, `SRB_OFF_SEGCNT, 2);
    bus(1, `SRB_OFF_CFG, 4);
    for (int i = 0; i < 5; i++)
      sweep(dl[i], i == 0 ? SL : i == 1 ? 2 : SL - 2 + $urandom % (SL + 6));
    // continuous modes: hold in mid-run, then stop or trigger; lead-out 3 in circular and stop-on-trigger only
    bus(1, `SRB_OFF_DELAY, 3);
    for (int m = 1; m < 4; m++) begin
      bus(1, `SRB_OFF_CFG, 4 | m);
      s0 = scnt;
      bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_RUN);
      ticks(4);
      bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_PAUSE);
      ticks(2);
      bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_RUN);
      ticks(3);
      // stop-on-trigger ends on the manual trigger bit, the others on stop
      bus(1, `SRB_OFF_CMD, 32'h1 << (m == 3 ? `SRB_CMD_TRIG : `SRB_CMD_STOP));
      ticks(5);
      check(scnt - s0, m == 1 ? 7 : 10);
      // running count in standard mode, ring offset of the 10th sample otherwise
      check(sa, m == 1 ? 6 : 1);
      bus(1, `SRB_OFF_CMD, 32'h1 << `SRB_CMD_STOP);
    end
    meas(4'h0, 1, 999, 1001);
    meas(4'h8, 1, 975, 978);
    meas(4'h0, 2, 1999, 2001);
    wrap_up;
  end
endmodule
